// ==== verilog/tlsc_list_scheduler.sv ====
`timescale 1ns/1ps
module tlsc_list_scheduler
	import tlsc_pkg::*;
#(
	parameter int FRAME_LEN = FRAME_CYCLES
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// microprocessor command and data ports
	input wire logic cmdWrStb,
	input wire logic dataWrStb,
	input wire logic dataRdStb,
	input wire logic [15:0] busWrData,
	output logic [15:0] busRdData,
	// host controller state
	input wire logic hostOperational,
	// usb transaction side
	input wire logic usbTxnDone,
	input wire logic [COUNT_W-1:0] usbTxnBytes,
	input wire logic usbTxnFatal,
	output logic usbTxnStart,
	output logic [BYTE_ADDR_W-1:0] usbTxnAddr,
	// frame and iso side
	output logic sofPulse,
	output logic isoSendValid,
	output logic [BYTE_ADDR_W-1:0] isoSendBase
);
	localparam logic [FRAME_CNT_W-1:0] FRAME_LAST = FRAME_CNT_W'(FRAME_LEN - 1);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [15:0] ram [0:RAM_WORDS-1];
	logic [7:0] cmd_r, cmd_nxt;
	logic hiWord_r, hiWord_nxt;
	logic [BYTE_ADDR_W-1:0] base_r, base_nxt;
	logic [BYTE_ADDR_W-1:0] ptr_r, ptr_nxt;
	logic busy_r, busy_nxt;
	logic bufSel_r, bufSel_nxt;
	logic [31:0] fmInterval_r, fmInterval_nxt;
	logic [31:0] lsThresh_r, lsThresh_nxt;
	logic [15:0] xferCount_r, xferCount_nxt;
	logic [15:0] itlLen_r, itlLen_nxt;
	logic [15:0] atlLen_r, atlLen_nxt;
	logic [2:0] irq_r, irq_nxt;
	logic atlFull_r, atlFull_nxt;
	logic atlDone_r, atlDone_nxt;
	logic [1:0] isoFull_r, isoFull_nxt;
	logic [1:0] isoDone_r, isoDone_nxt;
	logic [1:0] isoStuck_r, isoStuck_nxt;
	logic hostSel_r, hostSel_nxt;
	logic atlPending_r, atlPending_nxt;
	logic engStart_r, engStart_nxt;
	logic [FRAME_CNT_W-1:0] frameCnt_r, frameCnt_nxt;
	logic [15:0] rdData_r, rdData_nxt;
	logic sof_r, sof_nxt;
	logic isoValid_r, isoValid_nxt;
	logic [BYTE_ADDR_W-1:0] isoBase_r, isoBase_nxt;
	logic engDone;
	logic [BYTE_ADDR_W-1:0] rdByte;
	logic [15:0] rdWord;
	tlsc_ram_if ramIf();

	// ping sits right after the ack list, pong right after ping
	function automatic logic [BYTE_ADDR_W-1:0] itlBase(input logic sel, input logic [15:0] ack_transfer_list,
		input logic [15:0] iso_transfer_list);
		itlBase = sel ? 13'(ack_transfer_list + iso_transfer_list) : 13'(ack_transfer_list);
	endfunction

	// register view, 32-bit registers come low word first
	function automatic logic [15:0] regRead(input logic [6:0] idx, input logic hi);
		logic [15:0] v;
		v = 16'h0000;
		unique case (idx)
			REG_FRAME_INTERVAL: v = hi ? fmInterval_r[31:16] : fmInterval_r[15:0];
			REG_LS_THRESHOLD: v = hi ? lsThresh_r[31:16] : lsThresh_r[15:0];
			REG_XFER_COUNT: v = xferCount_r;
			REG_IRQ_STATUS: v = {13'h0000, irq_r};
			REG_ITL_LENGTH: v = itlLen_r;
			REG_ATL_LENGTH: v = atlLen_r;
			REG_BUF_STATUS: v = {10'h000, atlDone_r, isoDone_r, atlFull_r, isoFull_r};
			default: v = 16'h0000;
		endcase
		regRead = v;
	endfunction

	// ----------------------------------------------------------------
	// buffer ram
	// ----------------------------------------------------------------
	// microprocessor writes win; an engine write-back in the same cycle is dropped
	always_ff @(posedge clock)
	begin
		if (dataWrStb && busy_r && cmd_r[7])
			ram[11'(base_r[BYTE_ADDR_W-1:1] + ptr_r[BYTE_ADDR_W-1:1])] <= busWrData;
		else if (ramIf.wr)
			ram[ramIf.addr] <= ramIf.wdata;
	end
	assign ramIf.rdata = ram[ramIf.addr];
	assign rdWord = ram[rdByte[WORD_ADDR_W:1]];

	// ----------------------------------------------------------------
	// command, data, flags and frame scheduling
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [6:0] idx;
		logic [6:0] newIdx;
		logic [BYTE_ADDR_W-1:0] nextPtr;
		logic [2:0] irqSet;
		logic [2:0] irqClr;
		logic lastWord;
		logic doneSel;
		idx = cmd_r[6:0];
		newIdx = busWrData[6:0] & CMD_INDEX_MASK[6:0];
		nextPtr = ptr_r + WORD_BYTES;
		lastWord = {3'b000, nextPtr} >= xferCount_r;
		irqSet = 3'b000;
		irqClr = 3'b000;
		doneSel = isoDone_r[0] ? 1'b0 : 1'b1;
		cmd_nxt = cmd_r;
		hiWord_nxt = hiWord_r;
		base_nxt = base_r;
		ptr_nxt = ptr_r;
		busy_nxt = busy_r;
		bufSel_nxt = bufSel_r;
		fmInterval_nxt = fmInterval_r;
		lsThresh_nxt = lsThresh_r;
		xferCount_nxt = xferCount_r;
		itlLen_nxt = itlLen_r;
		atlLen_nxt = atlLen_r;
		atlFull_nxt = atlFull_r;
		atlDone_nxt = atlDone_r;
		isoFull_nxt = isoFull_r;
		isoDone_nxt = isoDone_r;
		isoStuck_nxt = isoStuck_r;
		hostSel_nxt = hostSel_r;
		atlPending_nxt = atlPending_r;
		engStart_nxt = 1'b0;
		rdData_nxt = rdData_r;
		sof_nxt = 1'b0;
		isoValid_nxt = isoValid_r;
		isoBase_nxt = isoBase_r;
		frameCnt_nxt = (frameCnt_r == '0) ? FRAME_LAST : frameCnt_r - 1'b1;
		rdByte = base_r + nextPtr;
		if (cmdWrStb)
		begin
			// a buffer command opens a burst with the pointer at the region start
			cmd_nxt = busWrData[7:0];
			hiWord_nxt = 1'b0;
			ptr_nxt = '0;
			busy_nxt = (newIdx == PORT_ATL) || (newIdx == PORT_ITL);
			bufSel_nxt = busWrData[7] ? ~hostSel_r : doneSel;
			base_nxt = (newIdx == PORT_ATL) ? '0 : itlBase(bufSel_nxt, atlLen_r, itlLen_r);
			rdByte = base_nxt;
			rdData_nxt = busy_nxt ? rdWord : regRead(newIdx, 1'b0);
		end
		else if ((dataWrStb || dataRdStb) && busy_r)
		begin
			ptr_nxt = nextPtr;
			rdData_nxt = rdWord;
			if (dataRdStb && idx == PORT_ITL && !isoStuck_r[bufSel_r])
			begin
				isoFull_nxt[bufSel_r] = 1'b0;
				isoDone_nxt[bufSel_r] = 1'b0;
			end
			if (lastWord)
			begin
				busy_nxt = 1'b0;
				irqSet[IRQ_EOT_BIT] = 1'b1;
				if (dataWrStb && idx == PORT_ATL)
				begin
					atlFull_nxt = 1'b1;
					atlDone_nxt = 1'b0;
					atlPending_nxt = hostOperational;
				end
				else if (dataWrStb)
					isoFull_nxt[bufSel_r] = 1'b1;
				else if (idx == PORT_ATL)
				begin
					atlFull_nxt = 1'b0;
					atlDone_nxt = 1'b0;
				end
			end
		end
		else if (dataWrStb && cmd_r[7])
		begin
			hiWord_nxt = ~hiWord_r;
			unique case (idx)
				REG_FRAME_INTERVAL:
					if (hiWord_r)
						fmInterval_nxt[31:16] = busWrData;
					else
						fmInterval_nxt[15:0] = busWrData;
				REG_LS_THRESHOLD:
					if (hiWord_r)
						lsThresh_nxt[31:16] = busWrData;
					else
						lsThresh_nxt[15:0] = busWrData;
				REG_XFER_COUNT: xferCount_nxt = busWrData;
				REG_IRQ_STATUS: irqClr = busWrData[2:0];
				REG_ITL_LENGTH: itlLen_nxt = busWrData;
				REG_ATL_LENGTH: atlLen_nxt = busWrData;
				default: irqClr = 3'b000;
			endcase
		end
		else if (dataRdStb && !cmd_r[7] && !hiWord_r)
		begin
			hiWord_nxt = 1'b1;
			rdData_nxt = regRead(idx, 1'b1);
		end
		if (frameCnt_r == '0)
		begin
			sof_nxt = 1'b1;
			// the buffer the host held last frame is now processed
			if (isoFull_nxt[hostSel_r])
				isoDone_nxt[hostSel_r] = 1'b1;
			// a result left unread for a whole frame locks that buffer
			if (isoDone_r[~hostSel_r])
			begin
				isoDone_nxt[~hostSel_r] = 1'b0;
				isoStuck_nxt[~hostSel_r] = 1'b1;
			end
			hostSel_nxt = (&isoFull_nxt) ? 1'b0 : ~hostSel_r;
			irqSet[IRQ_ITL_BIT] = (itlLen_r != 16'h0000);
			isoValid_nxt = isoFull_nxt[hostSel_nxt] && !(busy_r && idx == PORT_ITL);
			isoBase_nxt = itlBase(hostSel_nxt, atlLen_r, itlLen_r);
			// any load still running at frame start defers the ack list
			if (atlPending_nxt && !busy_r)
			begin
				engStart_nxt = 1'b1;
				atlPending_nxt = 1'b0;
			end
		end
		if (engDone)
		begin
			atlDone_nxt = 1'b1;
			irqSet[IRQ_ATL_BIT] = 1'b1;
		end
		// a new event wins over a clear in the same cycle
		irq_nxt = (irq_r & ~irqClr) | irqSet;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cmd_r <= 8'h00;
			hiWord_r <= 1'b0;
			base_r <= '0;
			ptr_r <= '0;
			busy_r <= 1'b0;
			bufSel_r <= 1'b0;
			fmInterval_r <= RST_WIDE_REG;
			lsThresh_r <= RST_WIDE_REG;
			xferCount_r <= RST_NARROW_REG;
			itlLen_r <= RST_NARROW_REG;
			atlLen_r <= RST_ATL_LENGTH;
			irq_r <= 3'b000;
			atlFull_r <= 1'b0;
			atlDone_r <= 1'b0;
			isoFull_r <= 2'b00;
			isoDone_r <= 2'b00;
			isoStuck_r <= 2'b00;
			hostSel_r <= 1'b1;
			atlPending_r <= 1'b0;
			engStart_r <= 1'b0;
			frameCnt_r <= '0;
			rdData_r <= 16'h0000;
			sof_r <= 1'b0;
			isoValid_r <= 1'b0;
			isoBase_r <= '0;
		end
		else
		begin
			cmd_r <= cmd_nxt;
			hiWord_r <= hiWord_nxt;
			base_r <= base_nxt;
			ptr_r <= ptr_nxt;
			busy_r <= busy_nxt;
			bufSel_r <= bufSel_nxt;
			fmInterval_r <= fmInterval_nxt;
			lsThresh_r <= lsThresh_nxt;
			xferCount_r <= xferCount_nxt;
			itlLen_r <= itlLen_nxt;
			atlLen_r <= atlLen_nxt;
			irq_r <= irq_nxt;
			atlFull_r <= atlFull_nxt;
			atlDone_r <= atlDone_nxt;
			isoFull_r <= isoFull_nxt;
			isoDone_r <= isoDone_nxt;
			isoStuck_r <= isoStuck_nxt;
			hostSel_r <= hostSel_nxt;
			atlPending_r <= atlPending_nxt;
			engStart_r <= engStart_nxt;
			frameCnt_r <= frameCnt_nxt;
			rdData_r <= rdData_nxt;
			sof_r <= sof_nxt;
			isoValid_r <= isoValid_nxt;
			isoBase_r <= isoBase_nxt;
		end
	end

	// ----------------------------------------------------------------
	// ack list engine
	// ----------------------------------------------------------------
	tlsc_list_engine engine (
		.clock(clock),
		.rst(rst),
		.start(engStart_r),
		.sof(sof_r),
		.listEnd(xferCount_r[BYTE_ADDR_W-1:0]),
		.ticksLeft(frameCnt_r >> TICK_SHIFT),
		.fsLargest(fmInterval_r[FS_LARGEST_MSB:FS_LARGEST_LSB]),
		.lsThresh(lsThresh_r[LS_THRESH_W-1:0]),
		.done(engDone),
		.txnDone(usbTxnDone),
		.txnBytes(usbTxnBytes),
		.txnFatal(usbTxnFatal),
		.txnStart(usbTxnStart),
		.txnAddr(usbTxnAddr),
		.ram(ramIf.engine)
	);

	assign busRdData = rdData_r;
	assign sofPulse = sof_r;
	assign isoSendValid = isoValid_r;
	assign isoSendBase = isoBase_r;
endmodule

// ==== verilog/tlsc_pkg.sv ====
package tlsc_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int FRAME_TIME_NS = 1000000;
	localparam int FRAME_CYCLES = FRAME_TIME_NS / CLOCK_PERIOD_NS;
	localparam int FRAME_CNT_W = 17;
	localparam int TICK_SHIFT = 3; // about one full-speed bit time per tick
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int BYTE_ADDR_W = 13;
	localparam int WORD_ADDR_W = 11;
	localparam int RAM_WORDS = 2048;
	localparam int COUNT_W = 10;
	localparam int FS_LARGEST_MSB = 30;
	localparam int FS_LARGEST_LSB = 16;
	localparam int LS_THRESH_W = 12;
	// ----------------------------------------------------------------
	// command port
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_WRITE_BIT = 8'h80;
	localparam logic [7:0] CMD_INDEX_MASK = 8'h7F;
	localparam logic [6:0] REG_FRAME_INTERVAL = 7'h0D;
	localparam logic [6:0] REG_LS_THRESHOLD = 7'h11;
	localparam logic [6:0] REG_XFER_COUNT = 7'h22;
	localparam logic [6:0] REG_IRQ_STATUS = 7'h24;
	localparam logic [6:0] REG_ITL_LENGTH = 7'h2A;
	localparam logic [6:0] REG_ATL_LENGTH = 7'h2B;
	localparam logic [6:0] REG_BUF_STATUS = 7'h2C;
	localparam logic [6:0] PORT_ITL = 7'h40;
	localparam logic [6:0] PORT_ATL = 7'h41;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int IRQ_ITL_BIT = 0;
	localparam int IRQ_ATL_BIT = 1;
	localparam int IRQ_EOT_BIT = 2;
	localparam int ST_ISO_FULL_LSB = 0;
	localparam int ST_ATL_FULL_BIT = 2;
	localparam int ST_ISO_DONE_LSB = 3;
	localparam int ST_ATL_DONE_BIT = 5;
	localparam int HDR_ACTIVE_BIT = 11;
	localparam int HDR_LOW_SPEED_BIT = 13;
	localparam logic [BYTE_ADDR_W-1:0] HDR_BYTES = 13'h0008;
	localparam logic [BYTE_ADDR_W-1:0] WORD_BYTES = 13'h0002;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_WIDE_REG = 32'h0000_0000;
	localparam logic [15:0] RST_NARROW_REG = 16'h0000;
	localparam logic [15:0] RST_ATL_LENGTH = 16'h1000;
endpackage

// ==== verilog/tlsc_ram_if.sv ====
`timescale 1ns/1ps
// word port of the list buffer ram shared by the scheduler engine
interface tlsc_ram_if;
	import tlsc_pkg::*;
	logic [WORD_ADDR_W-1:0] addr;
	logic wr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	modport engine (output addr, output wr, output wdata, input rdata);
	modport ram (input addr, input wr, input wdata, output rdata);
endinterface

// ==== verilog/tlsc_list_engine.sv ====
`timescale 1ns/1ps
module tlsc_list_engine
	import tlsc_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// control from the scheduler
	input wire logic start,
	input wire logic sof,
	input wire logic [BYTE_ADDR_W-1:0] listEnd,
	input wire logic [FRAME_CNT_W-1:0] ticksLeft,
	input wire logic [14:0] fsLargest,
	input wire logic [LS_THRESH_W-1:0] lsThresh,
	output logic done,
	// usb transaction side
	input wire logic txnDone,
	input wire logic [COUNT_W-1:0] txnBytes,
	input wire logic txnFatal,
	output logic txnStart,
	output logic [BYTE_ADDR_W-1:0] txnAddr,
	// buffer ram
	tlsc_ram_if.engine ram
);
	typedef enum logic [5:0] {
		E_IDLE = 6'b000001,
		E_HDR0 = 6'b000010,
		E_HDR1 = 6'b000100,
		E_HDR2 = 6'b001000,
		E_WAIT = 6'b010000,
		E_NEXT = 6'b100000
	} tlsc_eng_state_t;

	tlsc_eng_state_t st_r, st_nxt;
	logic [BYTE_ADDR_W-1:0] ptr_r, ptr_nxt;
	logic [15:0] h0_r, h0_nxt;
	logic [COUNT_W-1:0] total_r, total_nxt;
	logic anyActive_r, anyActive_nxt;
	logic sofSeen_r, sofSeen_nxt;
	logic done_r, done_nxt;
	logic txnStart_r, txnStart_nxt;
	logic [BYTE_ADDR_W-1:0] txnAddr_r, txnAddr_nxt;

	// a packet may start only if the frame still has room past its end mark
	function automatic logic timeOk(input logic lowSpeed, input logic [FRAME_CNT_W-1:0] ticks,
		input logic [14:0] fs, input logic [LS_THRESH_W-1:0] ls);
		timeOk = lowSpeed ? (ticks > {5'h00, ls}) : (ticks > {2'h0, fs});
	endfunction

	// ----------------------------------------------------------------
	// descriptor walk
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [COUNT_W:0] sum;
		logic [15:0] newH0;
		sum = {1'b0, h0_r[COUNT_W-1:0]} + {1'b0, txnBytes};
		newH0 = h0_r;
		st_nxt = st_r;
		ptr_nxt = ptr_r;
		h0_nxt = h0_r;
		total_nxt = total_r;
		anyActive_nxt = anyActive_r;
		sofSeen_nxt = sofSeen_r | sof;
		done_nxt = 1'b0;
		txnStart_nxt = 1'b0;
		txnAddr_nxt = txnAddr_r;
		ram.addr = ptr_r[WORD_ADDR_W:1];
		ram.wr = 1'b0;
		ram.wdata = h0_r;
		unique case (st_r)
			E_IDLE:
			begin
				sofSeen_nxt = 1'b0;
				if (start)
				begin
					ptr_nxt = '0;
					anyActive_nxt = 1'b0;
					st_nxt = E_HDR0;
				end
			end
			E_HDR0:
			begin
				if (ptr_r >= listEnd)
				begin
					// rescan only inside the same frame and only with time left
					if (anyActive_r && !sofSeen_r && timeOk(1'b0, ticksLeft, fsLargest, lsThresh))
					begin
						ptr_nxt = '0;
						anyActive_nxt = 1'b0;
					end
					else
					begin
						done_nxt = 1'b1;
						st_nxt = E_IDLE;
					end
				end
				else
				begin
					h0_nxt = ram.rdata;
					st_nxt = E_HDR1;
				end
			end
			E_HDR1:
			begin
				ram.addr = 11'(ptr_r[BYTE_ADDR_W-1:1] + 12'h001);
				total_nxt = ram.rdata[COUNT_W-1:0];
				st_nxt = E_HDR2;
			end
			E_HDR2:
			begin
				ram.addr = 11'(ptr_r[BYTE_ADDR_W-1:1] + 12'h002);
				if (h0_r[HDR_ACTIVE_BIT] && !sofSeen_r &&
					timeOk(ram.rdata[HDR_LOW_SPEED_BIT], ticksLeft, fsLargest, lsThresh))
				begin
					txnStart_nxt = 1'b1;
					txnAddr_nxt = ptr_r;
					st_nxt = E_WAIT;
				end
				else
				begin
					anyActive_nxt = anyActive_r | h0_r[HDR_ACTIVE_BIT];
					st_nxt = E_NEXT;
				end
			end
			E_WAIT:
			begin
				if (txnDone)
				begin
					newH0[COUNT_W-1:0] = sum[COUNT_W-1:0];
					if (sum >= {1'b0, total_r} || txnFatal)
						newH0[HDR_ACTIVE_BIT] = 1'b0;
					else
						anyActive_nxt = 1'b1;
					ram.wr = 1'b1;
					ram.wdata = newH0;
					h0_nxt = newH0;
					st_nxt = E_NEXT;
				end
			end
			E_NEXT:
			begin
				// payload space is rounded up to the next dword
				ptr_nxt = ptr_r + HDR_BYTES + ((13'(total_r) + 13'h0003) & 13'h1FFC);
				st_nxt = E_HDR0;
			end
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			st_r <= E_IDLE;
			ptr_r <= '0;
			h0_r <= 16'h0000;
			total_r <= '0;
			anyActive_r <= 1'b0;
			sofSeen_r <= 1'b0;
			done_r <= 1'b0;
			txnStart_r <= 1'b0;
			txnAddr_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
			ptr_r <= ptr_nxt;
			h0_r <= h0_nxt;
			total_r <= total_nxt;
			anyActive_r <= anyActive_nxt;
			sofSeen_r <= sofSeen_nxt;
			done_r <= done_nxt;
			txnStart_r <= txnStart_nxt;
			txnAddr_r <= txnAddr_nxt;
		end
	end

	assign done = done_r;
	assign txnStart = txnStart_r;
	assign txnAddr = txnAddr_r;
endmodule

// ==== verilog/_unused.sv ====
`timescale 1ns/1ps

// ==== testbench/tlsc_list_scheduler_monitor.sv ====
`timescale 1ns/1ps
module tlsc_list_scheduler_monitor
	import tlsc_pkg::*;
#(
	parameter int FRAME_LEN = FRAME_CYCLES
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// microprocessor ports
	input wire logic cmdWrStb,
	input wire logic dataWrStb,
	input wire logic dataRdStb,
	input wire logic [15:0] busWrData,
	input wire logic [15:0] busRdData,
	// usb transaction side
	input wire logic usbTxnDone,
	input wire logic usbTxnStart,
	input wire logic [BYTE_ADDR_W-1:0] usbTxnAddr,
	// frame and iso side
	input wire logic sofPulse,
	input wire logic isoSendValid,
	input wire logic [BYTE_ADDR_W-1:0] isoSendBase
);
	// ----------------------------------------
	// frame spacing
	// ----------------------------------------
	logic [31:0] frameCnt_r, frameCnt_nxt;
	logic sofSeen_r, sofSeen_nxt;
	// the first frame after reset has no reference start, so it is not measured
	always_comb
	begin
		frameCnt_nxt = (rst || sofPulse) ? 32'h0000_0000 : frameCnt_r + 32'h0000_0001;
		sofSeen_nxt = !rst && (sofSeen_r || sofPulse);
	end
	always_ff @(posedge clock)
	begin
		frameCnt_r <= frameCnt_nxt;
		sofSeen_r <= sofSeen_nxt;
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence sofEdge;
		sofPulse;
	endsequence
	sequence quietRun;
		!sofPulse [*8];
	endsequence
	sequence unmappedRead;
		cmdWrStb && busWrData[7:0] == 8'h7F;
	endsequence
	chk_frame_period: assert property (sofSeen_r && sofPulse |-> frameCnt_r == FRAME_LEN - 1)
		else $error("frame start spacing wrong");
	chk_sof_single: assert property (sofEdge |=> quietRun)
		else $error("frame start not a lone pulse");
	chk_txn_gap: assert property (usbTxnDone |=> !usbTxnStart [*3])
		else $error("next descriptor started too soon");
	chk_txn_aligned: assert property (usbTxnStart |-> usbTxnAddr[1:0] == 2'h0)
		else $error("descriptor address not on a dword");
	chk_addr_hold: assert property ($changed(usbTxnAddr) |-> usbTxnStart)
		else $error("descriptor address moved without a start");
	chk_rd_stable: assert property (!(cmdWrStb || dataWrStb || dataRdStb) |=> $stable(busRdData))
		else $error("read data changed without a strobe");
	chk_unmapped_zero: assert property (unmappedRead |=> busRdData == 16'h0000)
		else $error("unmapped read not zero");
	chk_iso_at_sof: assert property ($changed({isoSendValid, isoSendBase}) |-> sofPulse || $past(sofPulse))
		else $error("iso buffer choice changed mid frame");
endmodule
bind tlsc_list_scheduler tlsc_list_scheduler_monitor #(.FRAME_LEN(FRAME_LEN)) i_tlsc_list_scheduler_monitor (
	.clock(clock), .rst(rst), .cmdWrStb(cmdWrStb), .dataWrStb(dataWrStb), .dataRdStb(dataRdStb),
	.busWrData(busWrData), .busRdData(busRdData), .usbTxnDone(usbTxnDone), .usbTxnStart(usbTxnStart),
	.usbTxnAddr(usbTxnAddr), .sofPulse(sofPulse), .isoSendValid(isoSendValid), .isoSendBase(isoSendBase));

// ==== testbench/tlsc_usb_model.sv ====
`timescale 1ns/1ps
module tlsc_usb_model
	import tlsc_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// scenario controls
	input wire logic slow,
	input wire logic fatal,
	input wire logic [COUNT_W-1:0] bytesCfg,
	// transaction handshake
	input wire logic txnStart,
	output logic txnDone,
	output logic [COUNT_W-1:0] txnBytes,
	output logic txnFatal
);
	logic busy;
	logic [4:0] left;
	// answer each start after a short or a long bus time
	always @(posedge clock)
	begin
		txnDone <= !rst && busy && left == 5'h00;
		busy <= !rst && (txnStart || (busy && left != 5'h00));
		left <= txnStart ? (slow ? 5'h14 : 5'h02) : left - 5'h01;
	end
	// result lines mean nothing between answers, so they show the inverse there
	assign txnBytes = txnDone ? bytesCfg : ~bytesCfg;
	assign txnFatal = txnDone ? fatal : ~fatal;
endmodule

// ==== testbench/test_tlsc_list_scheduler.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module test_tlsc_list_scheduler
	import tlsc_pkg::*;
;
	localparam int FLEN = 400;
	logic clock, rst, cmdWrStb, dataWrStb, dataRdStb, hostOperational, slow, fatal;
	logic usbTxnDone, usbTxnFatal, usbTxnStart, sofPulse, isoSendValid;
	logic [15:0] busWrData, busRdData, v;
	logic [COUNT_W-1:0] usbTxnBytes, bytesCfg;
	logic [BYTE_ADDR_W-1:0] usbTxnAddr, isoSendBase;
	logic [BYTE_ADDR_W-1:0] starts[$];
	int errors, checked;
	// ----------------------------------------
	// design and usb side
	// ----------------------------------------
	tlsc_list_scheduler #(.FRAME_LEN(FLEN)) i_tlsc_list_scheduler (.clock(clock), .rst(rst),
		.cmdWrStb(cmdWrStb), .dataWrStb(dataWrStb), .dataRdStb(dataRdStb), .busWrData(busWrData),
		.busRdData(busRdData), .hostOperational(hostOperational), .usbTxnDone(usbTxnDone),
		.usbTxnBytes(usbTxnBytes), .usbTxnFatal(usbTxnFatal), .usbTxnStart(usbTxnStart),
		.usbTxnAddr(usbTxnAddr), .sofPulse(sofPulse), .isoSendValid(isoSendValid),
		.isoSendBase(isoSendBase));
	tlsc_usb_model i_tlsc_usb_model (.clock(clock), .rst(rst), .slow(slow), .fatal(fatal),
		.bytesCfg(bytesCfg), .txnStart(usbTxnStart), .txnDone(usbTxnDone), .txnBytes(usbTxnBytes),
		.txnFatal(usbTxnFatal));
	// free running clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// record descriptor starts away from the launching edge
	always @(negedge clock)
		if (usbTxnStart === 1'b1) starts.push_back(usbTxnAddr);
	// ----------------------------------------
	// port cycles
	// ----------------------------------------
	task automatic cmd(input logic [7:0] c);
		@(posedge clock);
		cmdWrStb <= 1'b1;
		busWrData <= {8'h00, c};
		@(posedge clock);
		cmdWrStb <= 1'b0;
	endtask
	task automatic wd(input logic [15:0] d);
		@(posedge clock);
		dataWrStb <= 1'b1;
		busWrData <= d;
		@(posedge clock);
		dataWrStb <= 1'b0;
	endtask
	task automatic rs;
		@(posedge clock);
		dataRdStb <= 1'b1;
		@(posedge clock);
		dataRdStb <= 1'b0;
	endtask
	task automatic regw(input logic [6:0] idx, input logic [15:0] d);
		cmd({1'b1, idx});
		wd(d);
	endtask
	// read data is settled by the falling edge after the command
	task automatic rd(input logic [6:0] idx, output logic [15:0] d);
		cmd({1'b0, idx});
		@(negedge clock);
		d = busRdData;
		rs;
	endtask
	task automatic wsof(input int n);
		int k;
		repeat (n)
			for (k = 0; k < FLEN + 4; k++)
			begin
				@(negedge clock);
				if (sofPulse === 1'b1) break;
			end
		`CHK("frame start", 1'b1, sofPulse)
	endtask
	task automatic rstDut;
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		starts.delete();
	endtask
	// four descriptors of 16, 8, 16 and 8 payload bytes, 0x50 bytes in all
	task automatic ackLoad;
		int d, k, t;
		regw(REG_IRQ_STATUS, 16'h0004);
		regw(REG_ATL_LENGTH, 16'h1000);
		regw(REG_XFER_COUNT, 16'h0050);
		cmd(8'hC1);
		for (d = 0; d < 4; d++)
		begin
			t = (d % 2 == 1) ? 8 : 16;
			wd(16'h0800);
			wd(16'h1000 | 16'(t));
			wd(16'h0800 | 16'(t));
			wd(16'h0005);
			for (k = 0; k < t / 2; k++) wd(16'(k));
		end
	endtask
	task automatic isoLoad;
		int k;
		regw(REG_ITL_LENGTH, 16'h0010);
		regw(REG_XFER_COUNT, 16'h0010);
		cmd(8'hC0);
		for (k = 0; k < 8; k++) wd(16'hA500 | 16'(k));
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs;
		rd(REG_ATL_LENGTH, v);
		`CHK("ack length", RST_ATL_LENGTH, v)
		rd(REG_XFER_COUNT, v);
		`CHK("byte count", 16'h0000, v)
		rd(7'h7F, v);
		`CHK("unmapped", 16'h0000, v)
		regw(REG_ITL_LENGTH, 16'h0020);
		rd(REG_ITL_LENGTH, v);
		`CHK("iso length", 16'h0020, v)
		$display("register test done");
	endtask
	task automatic t_ack_idle;
		rstDut;
		hostOperational <= 1'b0;
		ackLoad;
		rd(REG_IRQ_STATUS, v);
		`CHK("idle irq", 3'h4, v[2:0])
		rd(REG_BUF_STATUS, v);
		`CHK("idle status", 2'h1, {v[5], v[2]})
		wsof(2);
		`CHK("idle traffic", 0, starts.size())
		regw(REG_IRQ_STATUS, 16'h0004);
		rd(REG_IRQ_STATUS, v);
		`CHK("irq clear", 1'b0, v[2])
		$display("idle load test done");
	endtask
	// 8 bytes a transaction leaves the 16 byte descriptors active for a rescan
	task automatic t_ack_run;
		logic [BYTE_ADDR_W-1:0] exp[6] = '{13'h0000, 13'h0018, 13'h0028, 13'h0040, 13'h0000, 13'h0028};
		int k;
		rstDut;
		hostOperational <= 1'b1;
		bytesCfg <= 10'h008;
		cmd({1'b1, REG_FRAME_INTERVAL});
		wd(16'h0000);
		wd(16'h0010);
		ackLoad;
		for (k = 0; k < 12; k++)
		begin
			rd(REG_BUF_STATUS, v);
			if (v[ST_ATL_DONE_BIT] === 1'b1) break;
			repeat (50) @(posedge clock);
		end
		`CHK("run done", 1'b1, v[ST_ATL_DONE_BIT])
		rd(REG_IRQ_STATUS, v);
		`CHK("run irq", 2'h3, v[2:1])
		`CHK("start count", 6, starts.size())
		for (k = 0; k < 6 && k < starts.size(); k++) `CHK("start address", exp[k], starts[k])
		$display("operational load test done");
	endtask
	// the frame start right after reset hands ping to the host, so the first load fills pong
	task automatic t_iso_read;
		rstDut;
		isoLoad;
		rd(REG_BUF_STATUS, v);
		`CHK("pong full", 5'h02, v[4:0])
		wsof(1);
		@(negedge clock);
		`CHK("host on pong", 1'b1, isoSendValid)
		`CHK("pong base", 13'(RST_ATL_LENGTH + 16'h0010), isoSendBase)
		rd(REG_IRQ_STATUS, v);
		`CHK("iso irq", 1'b1, v[IRQ_ITL_BIT])
		wsof(1);
		rd(REG_BUF_STATUS, v);
		`CHK("pong done", 5'h12, v[4:0])
		regw(REG_XFER_COUNT, 16'h0002);
		cmd(8'h40);
		rs;
		rd(REG_BUF_STATUS, v);
		`CHK("pong freed", 5'h00, v[4:0])
		$display("iso read test done");
	endtask
	// an unread done buffer locks, and only reset frees it
	task automatic t_iso_lock;
		rstDut;
		isoLoad;
		wsof(3);
		rd(REG_BUF_STATUS, v);
		`CHK("pong stuck", 2'h1, {v[4], v[1]})
		rstDut;
		rd(REG_BUF_STATUS, v);
		`CHK("reset frees", 5'h00, v[4:0])
		$display("iso lock test done");
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// main sequence
	initial
	begin
		errors = 0;
		checked = 0;
		rst = 1'b1;
		cmdWrStb = 1'b0;
		dataWrStb = 1'b0;
		dataRdStb = 1'b0;
		busWrData = 16'h0000;
		hostOperational = 1'b0;
		slow = 1'b0;
		fatal = 1'b0;
		bytesCfg = 10'h010;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		t_regs;
		t_ack_idle;
		t_ack_run;
		t_iso_read;
		t_iso_lock;
		give_verdict;
	end
	// hang guard, well beyond the few thousand cycles the scenarios need
	initial
	begin
		repeat (30000) @(posedge clock);
		errors++;
		give_verdict;
	end
endmodule
